// ### bench/mcs_ctrl_status_bench.sv
// Purpose: self-checking bench for mcs_ctrl_status
// Assumes: host model drives register port and host pins
// Notes:   wake timer shortened to WAKE cycles
module mcs_ctrl_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import mcs_pkg::*;

  localparam int WAKE = 20;
  logic       clock, rstn, wr, rd, low_power_pin, module_reset_n, interrupt_out_n, low_power_out;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] receive_signal_loss_flag_in, tx_los_in, tx_fault_in, tx_out_en, rx_out_en, rate_sel_out;
  logic [2:0] other_cond_in;
  logic [7:0] regs [5] = '{ADDR_DIS, ADDR_MISC, ADDR_MASK_A, ADDR_MASK_B, 8'h40};
  int         failures = 0;
  int         total_checks = 0;

  mcs_host_model host (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .low_power_pin(low_power_pin), .module_reset_n(module_reset_n));
  mcs_ctrl_status #(.WAKE_CYCLES(WAKE)) DUT (.clock(clock), .rstn(rstn), .ce(1'b1), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .low_power_pin(low_power_pin),
    .module_reset_n(module_reset_n), .interrupt_out_n(interrupt_out_n), .receive_signal_loss_flag_in(receive_signal_loss_flag_in),
    .tx_los_in(tx_los_in), .tx_fault_in(tx_fault_in), .other_cond_in(other_cond_in),
    .tx_out_en(tx_out_en), .rx_out_en(rx_out_en), .rate_sel_out(rate_sel_out),
    .low_power_out(low_power_out));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] d;
    host.read_reg(a, d);
    check(d, exp, msg);
  endtask

  // waits for the ready interrupt of a wake-up, then clears it
  task automatic wait_full();
    int n;
    n = 0;
    while (interrupt_out_n !== 1'b0 && n < WAKE + 40) begin
      wait_cyc(1);
      n++;
    end
    check(interrupt_out_n, 1'b0, "ready int");
    check({low_power_out, tx_out_en}, 8'h0f, "full lanes");
    rd_chk(ADDR_STATUS, 8'h00, "status");
    rd_chk(ADDR_FLAG_B, 8'h10, "ready flag");
    wait_cyc(4);
    check(interrupt_out_n, 1'b1, "int release");
  endtask

  // kind: 0 rx loss, 1 tx fault, 2 tx loss, 3 other
  task automatic t_flag(input int kind, input int i);
    logic [7:0] en;
    int         pos;
    en = kind == 0 ? {4'hf, 4'hf & ~(4'h1 << i)} : kind == 2 ? {4'hf & ~(4'h1 << i), 4'hf} : 8'hff;
    pos = kind == 1 ? 4 + i : kind == 3 ? 5 + i : i;
    @(posedge clock);
    case (kind)
      0: receive_signal_loss_flag_in[i] <= 1'b1;
      1: tx_fault_in[i] <= 1'b1;
      2: tx_los_in[i] <= 1'b1;
      default: other_cond_in[i] <= 1'b1;
    endcase
    wait_cyc(6);
    check(interrupt_out_n, 1'b0, "flag int");
    check({tx_out_en, rx_out_en}, en, "squelch");
    rd_chk(kind < 2 ? ADDR_LIVE_A : ADDR_LIVE_B, 8'h01 << pos, "live");
    rd_chk(kind < 2 ? ADDR_FLAG_A : ADDR_FLAG_B, 8'h01 << pos, "flag");
    wait_cyc(4);
    check(interrupt_out_n, 1'b1, "cleared");
    receive_signal_loss_flag_in <= 4'h0;
    tx_fault_in <= 4'h0;
    tx_los_in <= 4'h0;
    other_cond_in <= 3'h0;
    wait_cyc(6);
    check({tx_out_en, rx_out_en}, 8'hff, "restore");
    rd_chk(kind < 2 ? ADDR_FLAG_A : ADDR_FLAG_B, 8'h00, "no refire");
  endtask

  task automatic t_mask_dis();
    @(posedge clock);
    receive_signal_loss_flag_in[0] <= 1'b1;
    wait_cyc(6);
    host.write_reg(ADDR_MASK_A, 8'h01);
    wait_cyc(3);
    check(interrupt_out_n, 1'b1, "masked");
    host.write_reg(ADDR_MASK_A, 8'h00);
    wait_cyc(3);
    check(interrupt_out_n, 1'b0, "unmasked");
    rd_chk(ADDR_FLAG_A, 8'h01, "mask flag");
    receive_signal_loss_flag_in <= 4'h0;
    host.write_reg(ADDR_DIS, 8'h31);
    wait_cyc(3);
    check({tx_out_en, rx_out_en}, 8'hec, "disable");
    host.write_reg(ADDR_DIS, 8'h00);
    wait_cyc(3);
    check({tx_out_en, rx_out_en}, 8'hff, "enable");
  endtask

  task automatic t_sqdis();
    host.write_reg(ADDR_MISC, 8'h02);
    @(posedge clock);
    receive_signal_loss_flag_in[1] <= 1'b1;
    tx_los_in[1] <= 1'b1;
    wait_cyc(6);
    check({tx_out_en, rx_out_en}, 8'hff, "squelch off");
    host.write_reg(ADDR_MISC, 8'h00);
    wait_cyc(3);
    check({tx_out_en, rx_out_en}, 8'hdd, "squelch on");
    receive_signal_loss_flag_in <= 4'h0;
    tx_los_in <= 4'h0;
    rd_chk(ADDR_FLAG_A, 8'h02, "sq flag a");
    rd_chk(ADDR_FLAG_B, 8'h02, "sq flag b");
  endtask

  task automatic t_power();
    logic [7:0] d;
    host.write_reg(ADDR_MISC, 8'ha0);
    wait_cyc(3);
    check(rate_sel_out, 4'ha, "rate");
    host.pin_reset(100);
    wait_cyc(6);
    rd_chk(ADDR_MISC, 8'ha0, "short low");
    host.pin_reset(280);
    wait_cyc(1);
    check(low_power_out, 1'b1, "pin reset");
    rd_chk(ADDR_MISC, 8'h00, "pin clears");
    wait_full();
    host.write_reg(ADDR_MISC, 8'h01);
    wait_cyc(4);
    check({low_power_out, tx_out_en}, 8'h10, "power down");
    host.read_reg(ADDR_STATUS, d);
    check(d & 8'h02, 8'h02, "low state");
    host.write_reg(ADDR_MISC, 8'h00);
    wait_full();
    host.set_lp(1'b1);
    wait_cyc(6);
    check(low_power_out, 1'b1, "lp pin");
    host.set_lp(1'b0);
    wait_full();
  endtask

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    end_sim();
  end

  initial begin
    rstn = 1'b0;
    receive_signal_loss_flag_in = 4'h0;
    tx_los_in = 4'h0;
    tx_fault_in = 4'h0;
    other_cond_in = 3'h0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    #1;
    check({interrupt_out_n, low_power_out}, 8'h03, "reset pins");
    check({tx_out_en, rx_out_en}, 8'h00, "reset lanes");
    foreach (regs[k]) begin
      rd_chk(regs[k], 8'h00, "reset value");
    end
    wait_full();
    host.write_reg(ADDR_STATUS, 8'hff);
    rd_chk(ADDR_STATUS, 8'h00, "read only");
    for (int kind = 0; kind < 4; kind++) begin
      for (int i = 0; i < (kind == 3 ? 3 : 4); i++) begin
        t_flag(kind, i);
      end
    end
    t_mask_dis();
    t_sqdis();
    t_power();
    end_sim();
  end
endmodule

// ### bench/mcs_ctrl_status_chk.sv
// Purpose: port timing checks for mcs_ctrl_status
// Assumes: ce held high
// Notes:   helper regs shadow squelch disable, lane 0 mask and reset pin low time
module mcs_ctrl_status_chk
  import mcs_pkg::*;
#(
  parameter int LANES  = 4,
  parameter int OTHERS = 3
) (
  // clock and reset
  input wire logic              clock,
  input wire logic              rstn,
  input wire logic              ce,
  // register port
  input wire logic [7:0]        addr,
  input wire logic [7:0]        wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [7:0]        rdata,
  // host pins
  input wire logic              low_power_pin,
  input wire logic              module_reset_n,
  input wire logic              interrupt_out_n,
  // lanes
  input wire logic [LANES-1:0]  receive_signal_loss_flag_in,
  input wire logic [LANES-1:0]  tx_los_in,
  input wire logic [LANES-1:0]  tx_fault_in,
  input wire logic [OTHERS-1:0] other_cond_in,
  input wire logic [LANES-1:0]  tx_out_en,
  input wire logic [LANES-1:0]  rx_out_en,
  input wire logic [LANES-1:0]  rate_sel_out,
  input wire logic              low_power_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       sq_off_reg;
  logic       mask0_reg;
  logic [9:0] low_cnt_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      sq_off_reg <= 1'b0;
    end else if (wr && addr == ADDR_MISC) begin
      sq_off_reg <= wdata[MISC_SQDIS];
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      mask0_reg <= 1'b0;
    end else if (wr && addr == ADDR_MASK_A) begin
      mask0_reg <= wdata[0];
    end
  end

  // consecutive low cycles on the reset pin, saturating
  always_ff @(posedge clock) begin
    if (!rstn || module_reset_n) begin
      low_cnt_reg <= 10'h000;
    end else if (low_cnt_reg != 10'h3ff) begin
      low_cnt_reg <= low_cnt_reg + 10'h001;
    end
  end

  property p_rd_idle;
    !$past(rd) |-> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
  property p_txdis;
    wr && addr == ADDR_DIS && wdata[0] |-> ##[1:3] !tx_out_en[0];
  endproperty
  a_txdis: assert property (p_txdis) else $error("transmit disable late");
  property p_rxdis;
    wr && addr == ADDR_DIS && wdata[4] |-> ##[1:3] !rx_out_en[0];
  endproperty
  a_rxdis: assert property (p_rxdis) else $error("receive disable late");
  property p_rxsq;
    $rose(receive_signal_loss_flag_in[0]) && !sq_off_reg |-> ##[1:4] !rx_out_en[0];
  endproperty
  a_rxsq: assert property (p_rxsq) else $error("receive squelch late");
  property p_lp_pin;
    low_power_pin [*6] |-> low_power_out;
  endproperty
  a_lp_pin: assert property (p_lp_pin) else $error("low power pin ignored");
  property p_pdown;
    wr && addr == ADDR_MISC && wdata[MISC_PDOWN] |-> ##[1:4] low_power_out;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power down late");
  property p_flag_int;
    $rose(receive_signal_loss_flag_in[0]) && !mask0_reg |-> ##[1:6] !interrupt_out_n;
  endproperty
  a_flag_int: assert property (p_flag_int) else $error("interrupt late");
  property p_pin_rst;
    low_cnt_reg == 10'h108 |-> low_power_out;
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pin reset not taken");
  property p_rate;
    wr && addr == ADDR_MISC |-> ##2 rate_sel_out == $past(wdata[7:4], 2);
  endproperty
  a_rate: assert property (p_rate) else $error("rate select not applied");

  c_read: cover property (rd ##1 rdata != 8'h00);
  c_int: cover property ($fell(interrupt_out_n));
  c_wake: cover property ($fell(low_power_out));
endmodule

bind mcs_ctrl_status mcs_ctrl_status_chk #(.LANES(LANES), .OTHERS(OTHERS)) u_chk (
  .clock(clock), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .low_power_pin(low_power_pin), .module_reset_n(module_reset_n),
  .interrupt_out_n(interrupt_out_n), .receive_signal_loss_flag_in(receive_signal_loss_flag_in), .tx_los_in(tx_los_in),
  .tx_fault_in(tx_fault_in), .other_cond_in(other_cond_in), .tx_out_en(tx_out_en),
  .rx_out_en(rx_out_en), .rate_sel_out(rate_sel_out), .low_power_out(low_power_out));

// ### bench/mcs_host_model.sv
// Purpose: host controller model: register port master and host pins
// Assumes: one access per call, strobes one cycle long
// Notes:   the strobe edge stands for the bus stop condition
module mcs_host_model (
  // clock
  input  wire logic       clock,
  // register port
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd,
  input  wire logic [7:0] rdata,
  // host pins
  output logic            low_power_pin,
  output logic            module_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    low_power_pin = 1'b0;
    module_reset_n = 1'b1;
  end

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // holds the reset pin low for n cycles
  task automatic pin_reset(input int n);
    @(posedge clock);
    module_reset_n <= 1'b0;
    repeat (n) @(posedge clock);
    module_reset_n <= 1'b1;
  endtask

  task automatic set_lp(input logic v);
    @(posedge clock);
    low_power_pin <= v;
  endtask
endmodule

// ### rtl/mcs_ctrl_status.sv
// Purpose: control and status logic of a four-lane pluggable module: flags, masks,
//          interrupt, power states, squelch and lane disables.
// Assumes: register port on the block clock; lane condition pins are asynchronous.
// Notes:   every software action takes effect within a few cycles, far inside the
//          latency bounds; only the wake-up sequence uses a long timer.
//
// Chosen here: the register addresses and the address-and-strobe port.

module mcs_ctrl_status
  import mcs_pkg::*;
#(
  parameter int          LANES      = 4,
  parameter int          OTHERS     = 3,
  parameter int          WAKE_CYCLES = mcs_pkg::WAKE_CYC,
  parameter bit          PWR_LVL1_MODULE = 1'b0
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             ce,
  // register port
  input  wire logic [7:0]       addr,
  input  wire logic [7:0]       wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic      [7:0]       rdata,
  // host pins
  input  wire logic             low_power_pin,
  input  wire logic             module_reset_n,
  output logic                  interrupt_out_n,
  // lane conditions
  input  wire logic [LANES-1:0] receive_signal_loss_flag_in,
  input  wire logic [LANES-1:0] tx_los_in,
  input  wire logic [LANES-1:0] tx_fault_in,
  input  wire logic [OTHERS-1:0] other_cond_in,
  // lane controls
  output logic      [LANES-1:0] tx_out_en,
  output logic      [LANES-1:0] rx_out_en,
  output logic      [LANES-1:0] rate_sel_out,
  output logic                  low_power_out
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  localparam int SW = 3 * LANES + OTHERS + 2;

  logic [SW-1:0]        pins_raw;
  logic [SW-1:0]        pins_s;
  logic [LANES-1:0]     receive_signal_loss_flag_s;
  logic [LANES-1:0]     tx_los_s;
  logic [LANES-1:0]     tx_fault_s;
  logic [OTHERS-1:0]    other_s;
  logic                 lp_pin_s;
  logic                 rst_pin_s;

  logic [LANES-1:0]     receive_signal_loss_flag_d_reg;
  logic [LANES-1:0]     tx_los_d_reg;
  logic [LANES-1:0]     tx_fault_d_reg;
  logic [OTHERS-1:0]    other_d_reg;
  logic [LANES-1:0]     receive_signal_loss_flag_rise;
  logic [LANES-1:0]     tx_los_rise;
  logic [LANES-1:0]     tx_fault_rise;
  logic [OTHERS-1:0]    other_rise;

  logic [RST_W-1:0]     rst_cnt_reg;
  logic                 pin_rst_reg;
  logic                 soft_clr;

  mcs_pwr_e             pwr_reg;
  mcs_pwr_e             pwr_next;
  logic [WAKE_W-1:0]    wake_cnt_reg;
  logic                 lp_req;
  logic                 ready_evt_reg;

  logic [7:0]           dis_reg;
  logic [7:0]           misc_reg;
  logic [7:0]           mask_a_reg;
  logic [7:0]           mask_b_reg;
  logic [7:0]           flag_a_reg;
  logic [7:0]           flag_b_reg;
  logic [7:0]           flag_a_set;
  logic [7:0]           flag_b_set;
  logic [7:0]           flag_a_clr;
  logic [7:0]           flag_b_clr;
  logic [7:0]           status_val;
  logic [7:0]           read_val;
  logic                 sq_dis;
  logic                 pdown;
  logic                 full_pwr;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  assign pins_raw = {module_reset_n, low_power_pin, other_cond_in, tx_fault_in, tx_los_in, receive_signal_loss_flag_in};

  mcs_sync #(
    .W       (SW),
    .RST_VAL ({1'b1, {(SW-1){1'b0}}})
  ) u_sync (
    .clock (clock),
    .rstn  (rstn),
    .ce    (ce),
    .d     (pins_raw),
    .q     (pins_s)
  );

  assign receive_signal_loss_flag_s   = pins_s[LANES-1:0];
  assign tx_los_s   = pins_s[2*LANES-1:LANES];
  assign tx_fault_s = pins_s[3*LANES-1:2*LANES];
  assign other_s    = pins_s[3*LANES+OTHERS-1:3*LANES];
  assign lp_pin_s   = pins_s[SW-2];
  assign rst_pin_s  = pins_s[SW-1];

  // ---------------------------------------------------------------
  // module reset pin filter
  // ---------------------------------------------------------------
  // a low level must outlast the filter time before it counts
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rst_cnt_reg <= '0;
      pin_rst_reg <= 1'b0;
    end else if (ce) begin
      if (rst_pin_s) begin
        rst_cnt_reg <= '0;
        pin_rst_reg <= 1'b0;
      end else if (rst_cnt_reg >= RST_W'(RST_CYC)) begin
        pin_rst_reg <= 1'b1;
      end else begin
        rst_cnt_reg <= rst_cnt_reg + RST_W'(1);
      end
    end
  end

  assign soft_clr = pin_rst_reg;

  // ---------------------------------------------------------------
  // condition edge detection
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      receive_signal_loss_flag_d_reg   <= '0;
      tx_los_d_reg   <= '0;
      tx_fault_d_reg <= '0;
      other_d_reg    <= '0;
    end else if (ce) begin
      receive_signal_loss_flag_d_reg   <= receive_signal_loss_flag_s;
      tx_los_d_reg   <= tx_los_s;
      tx_fault_d_reg <= tx_fault_s;
      other_d_reg    <= other_s;
    end
  end

  assign receive_signal_loss_flag_rise   = receive_signal_loss_flag_s & ~receive_signal_loss_flag_d_reg;
  assign tx_los_rise   = tx_los_s & ~tx_los_d_reg;
  assign tx_fault_rise = tx_fault_s & ~tx_fault_d_reg;
  assign other_rise    = other_s & ~other_d_reg;

  // ---------------------------------------------------------------
  // power state machine
  // ---------------------------------------------------------------
  assign pdown = misc_reg[MISC_PDOWN];
  // a level-1 module already runs at level 1, so it ignores low-power requests
  assign lp_req = PWR_LVL1_MODULE ? 1'b0 : (lp_pin_s | pdown);

  always_comb begin
    pwr_next = pwr_reg;
    if (soft_clr) begin
      pwr_next = PWR_RESET;
    end else begin
      unique case (pwr_reg)
        PWR_RESET: begin
          pwr_next = lp_req ? PWR_LOW : PWR_WAKE;
        end
        PWR_LOW: begin
          if (!lp_req) begin
            pwr_next = PWR_WAKE;
          end
        end
        PWR_WAKE: begin
          if (lp_req) begin
            pwr_next = PWR_LOW;
          end else if (wake_cnt_reg >= WAKE_W'(WAKE_CYCLES - 1)) begin
            pwr_next = PWR_FULL;
          end
        end
        PWR_FULL: begin
          if (lp_req) begin
            pwr_next = PWR_LOW;
          end
        end
        default: begin
          pwr_next = PWR_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pwr_reg <= PWR_RESET;
    end else if (ce) begin
      pwr_reg <= pwr_next;
    end
  end

  // wake timer runs only while waking
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wake_cnt_reg <= '0;
    end else if (ce) begin
      if (pwr_reg == PWR_WAKE && pwr_next == PWR_WAKE) begin
        wake_cnt_reg <= wake_cnt_reg + WAKE_W'(1);
      end else begin
        wake_cnt_reg <= '0;
      end
    end
  end

  // monitor data becomes ready on entry to full power
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ready_evt_reg <= 1'b0;
    end else if (ce) begin
      ready_evt_reg <= (pwr_next == PWR_FULL) && (pwr_reg != PWR_FULL);
    end
  end

  assign full_pwr = (pwr_reg == PWR_FULL);

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn || (ce && soft_clr)) begin
      dis_reg  <= DIS_RST;
      misc_reg <= MISC_RST;
    end else if (ce && wr) begin
      if (addr == ADDR_DIS) begin
        dis_reg <= wdata;
      end
      if (addr == ADDR_MISC) begin
        misc_reg <= wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn || (ce && soft_clr)) begin
      mask_a_reg <= MASK_RST;
      mask_b_reg <= MASK_RST;
    end else if (ce && wr) begin
      if (addr == ADDR_MASK_A) begin
        mask_a_reg <= wdata;
      end
      if (addr == ADDR_MASK_B) begin
        mask_b_reg <= wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // latched flags, cleared on read
  // ---------------------------------------------------------------
  always_comb begin
    flag_a_set = {tx_fault_rise, receive_signal_loss_flag_rise};
    flag_b_set = {other_rise, ready_evt_reg, tx_los_rise};
    flag_a_clr = (rd && addr == ADDR_FLAG_A) ? flag_a_reg : 8'h00;
    flag_b_clr = (rd && addr == ADDR_FLAG_B) ? flag_b_reg : 8'h00;
  end

  // only the bits returned by the read are cleared; a new event in that cycle stays set
  always_ff @(posedge clock) begin
    if (!rstn || (ce && soft_clr)) begin
      flag_a_reg <= 8'h00;
      flag_b_reg <= 8'h00;
    end else if (ce) begin
      flag_a_reg <= (flag_a_reg & ~flag_a_clr) | flag_a_set;
      flag_b_reg <= (flag_b_reg & ~flag_b_clr) | flag_b_set;
    end
  end

  // ---------------------------------------------------------------
  // interrupt output
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      interrupt_out_n <= 1'b1;
    end else if (ce) begin
      interrupt_out_n <= ~|((flag_a_reg & ~mask_a_reg) | (flag_b_reg & ~mask_b_reg));
    end
  end

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  always_comb begin
    status_val                 = 8'h00;
    status_val[STAT_NOT_READY] = ~full_pwr;
    status_val[STAT_LOW_POWER] = (pwr_reg == PWR_LOW);
  end

  always_comb begin
    read_val = 8'h00;
    unique case (addr)
      ADDR_STATUS: read_val = status_val;
      ADDR_FLAG_A: read_val = flag_a_reg;
      ADDR_FLAG_B: read_val = flag_b_reg;
      ADDR_DIS:    read_val = dis_reg;
      ADDR_MISC:   read_val = misc_reg;
      ADDR_MASK_A: read_val = mask_a_reg;
      ADDR_MASK_B: read_val = mask_b_reg;
      ADDR_LIVE_A: read_val = {tx_fault_s, receive_signal_loss_flag_s};
      ADDR_LIVE_B: read_val = {other_s, 1'b0, tx_los_s};
      default:     read_val = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= rd ? read_val : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // lane outputs: squelch, disables, rate
  // ---------------------------------------------------------------
  assign sq_dis = misc_reg[MISC_SQDIS];

  always_ff @(posedge clock) begin
    if (!rstn) begin
      tx_out_en <= '0;
      rx_out_en <= '0;
    end else if (ce) begin
      for (int i = 0; i < LANES; i++) begin
        tx_out_en[i] <= full_pwr & ~dis_reg[i] & ~(tx_los_s[i] & ~sq_dis);
        rx_out_en[i] <= full_pwr & ~dis_reg[HI_NIB_LSB + i] & ~(receive_signal_loss_flag_s[i] & ~sq_dis);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rate_sel_out <= '0;
    end else if (ce) begin
      rate_sel_out <= misc_reg[MISC_RATE_LSB +: LANES];
    end
  end

  // level 1 is held in reset and low-power states
  always_ff @(posedge clock) begin
    if (!rstn) begin
      low_power_out <= 1'b1;
    end else if (ce) begin
      low_power_out <= (pwr_next == PWR_LOW) || (pwr_next == PWR_RESET);
    end
  end

endmodule

// ### rtl/mcs_pkg.sv
// Purpose: constants, register map and power states for the module control/status block,
//          plus the two-flop input synchroniser that the block uses for every pin.
// Assumes: 125 MHz clock, 8-bit register port.
// Notes:   how it works:

package mcs_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ      = 125000;
  localparam int T_RST_US     = 2;
  localparam int RST_CYC      = (T_RST_US * CLK_KHZ + 999) / 1000;
  localparam int T_LPOFF_MS   = 300;
  localparam int LPOFF_CYC    = T_LPOFF_MS * CLK_KHZ;
  localparam int T_PDOFF_MS   = 300;
  localparam int PDOFF_CYC    = T_PDOFF_MS * CLK_KHZ;
  localparam int WAKE_MARGIN  = 8;
  localparam int WAKE_CYC     = ((LPOFF_CYC < PDOFF_CYC) ? LPOFF_CYC : PDOFF_CYC) - WAKE_MARGIN;
  localparam int WAKE_W       = 26;
  localparam int RST_W        = 9;
  localparam int T_LPON_US    = 100;
  localparam int LPON_CYC     = T_LPON_US * CLK_KHZ / 1000;
  localparam int T_INTOFF_US  = 500;
  localparam int INTOFF_CYC   = T_INTOFF_US * CLK_KHZ / 1000;
  localparam int T_RXSQ_US    = 80;
  localparam int RXSQ_CYC     = T_RXSQ_US * CLK_KHZ / 1000;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS  = 8'h02;
  localparam logic [7:0] ADDR_FLAG_A  = 8'h03;
  localparam logic [7:0] ADDR_FLAG_B  = 8'h04;
  localparam logic [7:0] ADDR_DIS     = 8'h05;
  localparam logic [7:0] ADDR_MISC    = 8'h06;
  localparam logic [7:0] ADDR_MASK_A  = 8'h07;
  localparam logic [7:0] ADDR_MASK_B  = 8'h08;
  localparam logic [7:0] ADDR_LIVE_A  = 8'h09;
  localparam logic [7:0] ADDR_LIVE_B  = 8'h0a;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int STAT_NOT_READY = 0;
  localparam int STAT_LOW_POWER = 1;
  localparam int MISC_PDOWN     = 0;
  localparam int MISC_SQDIS     = 1;
  localparam int MISC_RATE_LSB  = 4;
  localparam int FLAGB_READY    = 4;
  localparam int FLAGB_OTH_LSB  = 5;
  localparam int HI_NIB_LSB     = 4;
  localparam logic [7:0] DIS_RST  = 8'h00;
  localparam logic [7:0] MISC_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;

  // ---------------------------------------------------------------
  // power states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    PWR_RESET = 4'b0001,
    PWR_LOW   = 4'b0010,
    PWR_WAKE  = 4'b0100,
    PWR_FULL  = 4'b1000
  } mcs_pwr_e;

endpackage

// two-flop synchroniser for pin inputs; the first flop feeds only the second
module mcs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and control
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else if (ce) begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
